// ==== pkg/rct_pkg.sv ====
package rct_pkg;
  // Register byte addresses (printed offsets are multiples of four).
  localparam logic [7:0] RCT_ADDR_CR0 = 8'hA0;
  localparam logic [7:0] RCT_ADDR_CR1 = 8'hA4;
  localparam logic [7:0] RCT_ADDR_CR2 = 8'hA8;
  localparam logic [7:0] RCT_ADDR_CNTL = 8'hAC;
  localparam logic [7:0] RCT_ADDR_CNTH = 8'hB0;
  localparam logic [7:0] RCT_ADDR_STAT = 8'hB4;
  localparam logic [7:0] RCT_ADDR_TIMER = 8'hB8;
  localparam logic [7:0] RCT_CR0_RST = 8'h00;
  localparam logic [7:0] RCT_CR1_RST = 8'h00;
  localparam logic [7:0] RCT_CR2_RST = 8'h00;
  localparam logic [5:0] RCT_TIMER_RST = 6'h00;
  // Control 0 field positions.
  localparam int RCT_CR0_EN = 0;
  localparam int RCT_CR0_MODE_LO = 1;
  localparam int RCT_CR0_OUT_LO = 6;
  // Control 1 field positions.
  localparam int RCT_CR1_CHAIN = 7;
  localparam int RCT_CR1_CLKSEL_LO = 5;
  localparam int RCT_CR1_INV = 3;
  localparam int RCT_CR1_INSEL_LO = 0;
  // Control 2 field positions.
  localparam int RCT_CR2_PXD = 2;
  typedef enum logic [1:0] {
    RCT_MODE_STOP_EVT = 2'b00,
    RCT_MODE_PULSE = 2'b01,
    RCT_MODE_PERIOD = 2'b10,
    RCT_MODE_CONT = 2'b11
  } rct_mode_e;
  typedef enum logic [1:0] {
    RCT_OUT_INPUT = 2'b00,
    RCT_OUT_IRQ = 2'b01,
    RCT_OUT_LOW = 2'b10,
    RCT_OUT_HIGH = 2'b11
  } rct_out_e;
  typedef enum logic [1:0] {
    RCT_ST_IDLE = 2'b00,
    RCT_ST_WAIT = 2'b01,
    RCT_ST_RUN = 2'b10,
    RCT_ST_HELD = 2'b11
  } rct_state_e;
  localparam logic [7:0] RCT_CNT_MAX = 8'hFF;
  localparam logic [7:0] RCT_CNT_ZERO = 8'h00;
  localparam logic [5:0] RCT_TMR_ZERO = 6'h00;
  localparam logic [2:0] RCT_DIV_MAX = 3'h7;
endpackage

// ==== hw/rct_sync2.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for one level from outside the clock domain.
module rct_sync2 import rct_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } rct_sync_s;
  rct_sync_s st_q;
  rct_sync_s st_d;
  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign dout = st_q.s2;
endmodule

// ==== hw/rct_top.sv ====
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Operation
// - Two 8-bit capture up-counters, optionally chained to one 16-bit counter.
// - Timer runs on relaxation clock or count clock; chained counter runs on divided count clock.
// - One write setting enable starts counters at once and the timer two clocks later, through the synchroniser.
// - Timer terminal count captures the 16-bit counter contents.
// - Timer is a 6-bit down counter with terminal count; starts on enable.
// - Enable passes a two-stage synchroniser into the timer clock domain.
// - Each start loads the timer data register and counts down to zero.
// - Timer is one-shot only; it stops after one cycle, no reload.
// - Disabling then re-enabling restarts the timer from its loaded value.
// - Proximity-drive enable selects timer clock: relaxation clock or count clock.
// - At zero the terminal count output is high for one main clock cycle.
// - Terminal count low for loaded value periods; period adds one clock.
// - Output select routes input, interrupt, low or high counter output to pin.
// - Mode 00 counts from enable and stops on the selected event.
// - Mode 01 counts from input rising edge to next falling edge.
// - Mode 10 counts from one input rising edge to the next.
// - Mode 11 runs continuously, interrupt every 100h or 10000h counts.
// - Enable one counts; enable zero stops and clears all counters.
// - A mode-event stop holds the count for reading.
// - Chain clear keeps counters independent; set makes one 16-bit counter.
// - Clock select divides the main clock by 1, 2, 4 or 8.
// - Status clears when disabled and updates only while enabled and out of idle.
module rct_top import rct_pkg::*; #(
  parameter int INSEL_W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Asynchronous event inputs and relaxation oscillator clock
  input wire logic [(1 << INSEL_W) - 1:0] event_in,
  input wire logic relaxation_osc_clock,
  // Outputs
  output logic sense_out,
  output logic timer_tc
);
  typedef struct packed {
    logic [7:0] cr0;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [5:0] tmr_data;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] cap_lo;
    logic [7:0] cap_hi;
    logic [5:0] tmr;
    logic tmr_run;
    logic tc;
    logic osc_prev;
    logic in_prev;
    logic [2:0] div;
    rct_state_e state;
    logic irq;
    logic out;
    logic ack;
    logic [31:0] rdata;
  } rct_s;
  rct_s st_q;
  rct_s st_d;

  logic en_sync;
  logic osc_sync;
  logic in_sync;
  logic en_raw;
  logic [INSEL_W - 1:0] insel;
  logic sel_in;

  assign en_raw = st_q.cr0[RCT_CR0_EN];
  assign insel = st_q.cr1[RCT_CR1_INSEL_LO +: INSEL_W];
  assign sel_in = event_in[insel];

  // The enable reaches the timer logic only through two flops.
  rct_sync2 u_en_sync (
    .clk(clk),
    .rst(rst),
    .din(en_raw),
    .dout(en_sync)
  );
  rct_sync2 u_osc_sync (
    .clk(clk),
    .rst(rst),
    .din(relaxation_osc_clock),
    .dout(osc_sync)
  );
  // Selected input is synchronised after the mux; the select is static while enabled.
  rct_sync2 u_in_sync (
    .clk(clk),
    .rst(rst),
    .din(sel_in),
    .dout(in_sync)
  );

  logic wr;
  logic rd_req;
  logic [1:0] clksel;
  logic cnt_tick;
  logic osc_rise;
  logic tmr_tick;
  logic in_pol;
  logic in_rise;
  logic in_fall;
  logic chain;
  logic lo_wrap;
  logic hi_wrap;
  logic count_en;
  logic stop_evt;
  rct_mode_e mode;

  always_comb begin
    st_d = st_q;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_q.ack && wb_sel_i[0];
    rd_req = wb_cyc_i && wb_stb_i && !st_q.ack;
    mode = rct_mode_e'(st_q.cr0[RCT_CR0_MODE_LO +: 2]);
    chain = st_q.cr1[RCT_CR1_CHAIN];
    clksel = st_q.cr1[RCT_CR1_CLKSEL_LO +: 2];
    // Divider gives a one-cycle enable at clk/1, /2, /4 or /8.
    st_d.div = st_q.div + 3'h1;
    case (clksel)
      2'b00: cnt_tick = 1'b1;
      2'b01: cnt_tick = st_q.div[0];
      2'b10: cnt_tick = &st_q.div[1:0];
      default: cnt_tick = (st_q.div == RCT_DIV_MAX);
    endcase
    st_d.osc_prev = osc_sync;
    osc_rise = osc_sync && !st_q.osc_prev;
    // Timer clock is the relaxation clock or the count clock.
    tmr_tick = st_q.cr2[RCT_CR2_PXD] ? cnt_tick : osc_rise;
    in_pol = in_sync ^ st_q.cr1[RCT_CR1_INV];
    st_d.in_prev = in_pol;
    in_rise = in_pol && !st_q.in_prev;
    in_fall = !in_pol && st_q.in_prev;

    // One-shot down-counting timer.
    st_d.tc = 1'b0;
    if (!en_sync) begin
      // Loaded while disabled so each enable restarts from the data value.
      st_d.tmr = st_q.tmr_data;
      st_d.tmr_run = 1'b1;
    end else if (st_q.tmr_run && tmr_tick) begin
      if (st_q.tmr == RCT_TMR_ZERO) begin
        st_d.tc = 1'b1;
        st_d.tmr_run = 1'b0;
      end else begin
        st_d.tmr = st_q.tmr - 6'h01;
      end
    end

    // Counter state machine.
    count_en = 1'b0;
    stop_evt = 1'b0;
    lo_wrap = (st_q.cnt_lo == RCT_CNT_MAX);
    hi_wrap = (st_q.cnt_hi == RCT_CNT_MAX);
    st_d.irq = 1'b0;
    case (st_q.state)
      RCT_ST_IDLE: begin
        if (en_raw) begin
          st_d.state = (mode == RCT_MODE_PULSE || mode == RCT_MODE_PERIOD)
            ? RCT_ST_WAIT : RCT_ST_RUN;
        end
      end
      RCT_ST_WAIT: begin
        if (in_rise) begin
          st_d.state = RCT_ST_RUN;
        end
      end
      RCT_ST_RUN: begin
        count_en = 1'b1;
        case (mode)
          RCT_MODE_STOP_EVT: stop_evt = in_rise;
          RCT_MODE_PULSE: stop_evt = in_fall;
          RCT_MODE_PERIOD: stop_evt = in_rise;
          default: stop_evt = 1'b0;
        endcase
        if (stop_evt) begin
          st_d.state = RCT_ST_HELD;
          st_d.irq = 1'b1;
        end
      end
      RCT_ST_HELD: begin
        st_d.state = RCT_ST_HELD;
      end
      default: st_d.state = RCT_ST_IDLE;
    endcase

    if (count_en && cnt_tick && !stop_evt) begin
      st_d.cnt_lo = st_q.cnt_lo + 8'h01;
      if (chain) begin
        if (lo_wrap) begin
          st_d.cnt_hi = st_q.cnt_hi + 8'h01;
        end
      end else begin
        st_d.cnt_hi = st_q.cnt_hi + 8'h01;
      end
      // Periodic interrupt every 100h counts, or 10000h when chained.
      if (mode == RCT_MODE_CONT && lo_wrap && (!chain || hi_wrap)) begin
        st_d.irq = 1'b1;
      end
    end

    // Timer terminal count captures the counter.
    if (st_q.tc && st_q.state != RCT_ST_IDLE) begin
      st_d.cap_lo = st_q.cnt_lo;
      st_d.cap_hi = st_q.cnt_hi;
    end

    // Output routing.
    case (rct_out_e'(st_q.cr0[RCT_CR0_OUT_LO +: 2]))
      RCT_OUT_INPUT: st_d.out = in_pol;
      RCT_OUT_IRQ: st_d.out = st_q.irq;
      RCT_OUT_LOW: st_d.out = lo_wrap && count_en;
      default: st_d.out = hi_wrap && count_en;
    endcase

    // Bus access: single-cycle ack, dropped the cycle after.
    st_d.ack = rd_req;
    if (rd_req) begin
      case (wb_adr_i)
        RCT_ADDR_CR0: st_d.rdata = {24'h000000, st_q.cr0};
        RCT_ADDR_CR1: st_d.rdata = {24'h000000, st_q.cr1};
        RCT_ADDR_CR2: st_d.rdata = {24'h000000, st_q.cr2};
        RCT_ADDR_CNTL: st_d.rdata = {24'h000000, st_q.cnt_lo};
        RCT_ADDR_CNTH: st_d.rdata = {24'h000000, st_q.cnt_hi};
        RCT_ADDR_STAT: st_d.rdata = {24'h000000, st_q.cap_hi};
        RCT_ADDR_TIMER: st_d.rdata = {26'h0000000, st_q.tmr_data};
        default: st_d.rdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        RCT_ADDR_CR0: st_d.cr0 = wb_dat_i[7:0];
        RCT_ADDR_CR1: st_d.cr1 = wb_dat_i[7:0];
        RCT_ADDR_CR2: st_d.cr2 = wb_dat_i[7:0];
        RCT_ADDR_TIMER: st_d.tmr_data = wb_dat_i[5:0];
        default: st_d.cr0 = st_q.cr0;
      endcase
    end

    // Disable stops counting and clears counters and capture.
    if (!en_raw) begin
      st_d.state = RCT_ST_IDLE;
      st_d.cnt_lo = RCT_CNT_ZERO;
      st_d.cnt_hi = RCT_CNT_ZERO;
      st_d.cap_lo = RCT_CNT_ZERO;
      st_d.cap_hi = RCT_CNT_ZERO;
      st_d.irq = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.cr0 <= RCT_CR0_RST;
      st_q.cr1 <= RCT_CR1_RST;
      st_q.cr2 <= RCT_CR2_RST;
      st_q.tmr_data <= RCT_TIMER_RST;
      st_q.state <= RCT_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdata;
  assign sense_out = st_q.out;
  assign timer_tc = st_q.tc;

  a_tc_one_cycle: assert property (@(posedge clk) disable iff (rst)
    st_q.tc |=> !st_q.tc) else $error("terminal count longer than one cycle");
  a_disable_clears: assert property (@(posedge clk) disable iff (rst)
    !en_raw |=> (st_q.cnt_lo == 8'h00 && st_q.cnt_hi == 8'h00)) else $error("counter not cleared");
  a_held_count: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == RCT_ST_HELD && en_raw) |=> $stable(st_q.cnt_lo))
    else $error("held count changed");
  a_wait_no_count: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == RCT_ST_WAIT && en_raw) |=> st_q.cnt_lo == $past(st_q.cnt_lo))
    else $error("counted while waiting for edge");
  a_chain_carry: assert property (@(posedge clk) disable iff (rst)
    (count_en && cnt_tick && !stop_evt && chain && !lo_wrap && en_raw) |=>
    $stable(st_q.cnt_hi)) else $error("high counter moved without carry");
  a_timer_oneshot: assert property (@(posedge clk) disable iff (rst)
    (st_q.tc && en_sync) |=> (!st_q.tmr_run && !st_q.tc)) else $error("timer reloaded");
  a_capture_tc: assert property (@(posedge clk) disable iff (rst)
    (st_q.tc && st_q.state != RCT_ST_IDLE && en_raw) |=> st_q.cap_lo == $past(st_q.cnt_lo))
    else $error("no capture on terminal count");
  a_ack_drop: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_disabled_load: assert property (@(posedge clk) disable iff (rst)
    !en_sync |=> st_q.tmr == $past(st_q.tmr_data)) else $error("timer not loaded");
endmodule

// ==== verif/rct_sense_model.sv ====
`timescale 1ns/1ps
// Oscillator and event sources at the far side of the block. The oscillator
// rests low between runs, so each run starts from a known phase.
module rct_sense_model #(
  parameter int HALF = 3
) (
  // Clock
  input wire logic clk,
  // Bench controls
  input wire logic osc_en,
  input wire logic [7:0] ev_lvl,
  // Towards the block
  output logic [7:0] event_in,
  output logic relaxation_osc_clock
);
  int ph;
  assign event_in = ev_lvl;
  always @(posedge clk) begin
    if (!osc_en) begin
      ph <= 0;
      relaxation_osc_clock <= 1'h0;
    end else if (ph == HALF - 1) begin
      ph <= 0;
      relaxation_osc_clock <= ~relaxation_osc_clock;
    end else begin
      ph <= ph + 1;
    end
  end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import rct_pkg::*;
  logic clk, rst, cyc, stb, we, osc_en, osc, ack, sense_out, timer_tc;
  logic [7:0] adr, ev, q, event_in;
  logic [31:0] wdat, rdat;
  int n_fail, n_checks;
  rct_top i_rct_top (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
    .event_in(event_in), .relaxation_osc_clock(osc), .sense_out(sense_out),
    .timer_tc(timer_tc));
  rct_sense_model i_rct_sense_model (.clk(clk), .osc_en(osc_en), .ev_lvl(ev),
    .event_in(event_in), .relaxation_osc_clock(osc));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'h1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'h1 && k < 50);
    chk(ack === 1'h1, "no bus answer");
    q = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic rise(output int n);
    logic p;
    n = 0;
    do begin
      p = sense_out;
      @(posedge clk);
      n++;
    end while (!(p === 1'h0 && sense_out === 1'h1) && n < 5000);
  endtask
  task automatic regs();
    logic [7:0] al [6] = '{RCT_ADDR_CR0, RCT_ADDR_CR1, RCT_ADDR_CR2, RCT_ADDR_TIMER,
      RCT_ADDR_CNTL, RCT_ADDR_CNTH};
    foreach (al[i]) begin
      wb(al[i], 1'h0, 8'h00);
      chk(q === 8'h00, "reset value");
    end
    wb(RCT_ADDR_CR1, 1'h1, 8'hEB);
    wb(RCT_ADDR_CR1, 1'h0, 8'h00);
    chk(q === 8'hEB, "control 1 readback");
    wb(RCT_ADDR_TIMER, 1'h1, 8'h2A);
    wb(RCT_ADDR_TIMER, 1'h0, 8'h00);
    chk(q === 8'h2A, "timer data readback");
    wb(8'hBC, 1'h1, 8'hFF);
    wb(8'hBC, 1'h0, 8'h00);
    chk(q === 8'h00, "unmapped read");
  endtask
  // The count window is opened by the enable or an input edge and closed by a later input edge.
  task automatic meas(input logic [1:0] md, input logic flip, input int w, input int lo_b,
      input int hi_b);
    logic a;
    logic [7:0] lo;
    logic [15:0] c;
    a = ~flip;
    ev <= {8{flip}};
    wb(RCT_ADDR_CR1, 1'h1, {1'h1, 3'h0, flip, 3'h0});
    wb(RCT_ADDR_CR0, 1'h1, {5'h00, md, 1'h1});
    repeat (5) @(posedge clk);
    if (md == 2'h0) begin
      repeat (w) @(posedge clk);
      ev[0] <= a;
    end else begin
      ev[0] <= a;
      repeat (md == 2'h1 ? w : 2) @(posedge clk);
      ev[0] <= ~a;
      if (md == 2'h2) begin
        repeat (w - 2) @(posedge clk);
        ev[0] <= a;
      end
    end
    repeat (12) @(posedge clk);
    wb(RCT_ADDR_CNTL, 1'h0, 8'h00);
    lo = q;
    wb(RCT_ADDR_CNTH, 1'h0, 8'h00);
    c = {q, lo};
    chk(c >= lo_b && c <= hi_b, "count out of range");
    repeat (20) @(posedge clk);
    wb(RCT_ADDR_CNTL, 1'h0, 8'h00);
    chk(q === lo, "count not held");
    wb(RCT_ADDR_CR0, 1'h1, 8'h00);
    wb(RCT_ADDR_CNTL, 1'h0, 8'h00);
    chk(q === 8'h00, "low not cleared");
    wb(RCT_ADDR_CNTH, 1'h0, 8'h00);
    chk(q === 8'h00, "high not cleared");
    ev <= 8'h00;
    // Let one edge pass so the next scenario's first input change is its own.
    @(posedge clk);
  endtask
  task automatic cont(input logic [1:0] dv);
    int n;
    wb(RCT_ADDR_CR1, 1'h1, {1'h0, dv, 5'h00});
    wb(RCT_ADDR_CR0, 1'h1, {1'h1, dv[0], 6'h07});
    rise(n);
    rise(n);
    chk(n == (256 << dv), "wrap period");
    wb(RCT_ADDR_CR0, 1'h1, 8'h00);
  endtask
  task automatic route();
    int n;
    for (int f = 0; f < 2; f++) begin
      wb(RCT_ADDR_CR1, 1'h1, {4'h0, f[0], 3'h1});
      wb(RCT_ADDR_CR0, 1'h1, 8'h07);
      ev[1] <= 1'h1;
      repeat (8) @(posedge clk);
      chk(sense_out === ~f[0], "input route high");
      ev[1] <= 1'h0;
      repeat (8) @(posedge clk);
      chk(sense_out === f[0], "input route low");
      wb(RCT_ADDR_CR0, 1'h1, 8'h00);
    end
    wb(RCT_ADDR_CR1, 1'h1, 8'h00);
    wb(RCT_ADDR_CR0, 1'h1, 8'h47);
    rise(n);
    chk(n < 300, "no interrupt on pin");
    wb(RCT_ADDR_CR0, 1'h1, 8'h00);
  endtask
  // Count clock cycles from the enable write to the terminal count; on the count clock
  // a short timer ends within a few cycles, so watching starts straight away.
  task automatic tmr(input logic [5:0] n, input logic cclk, output int t,
      output logic [7:0] cap);
    int k;
    k = 0;
    t = 0;
    wb(RCT_ADDR_CR1, 1'h1, 8'h80);
    wb(RCT_ADDR_CR2, 1'h1, {5'h00, cclk, 2'h0});
    wb(RCT_ADDR_TIMER, 1'h1, {2'h0, n});
    wb(RCT_ADDR_CR0, 1'h1, 8'h01);
    osc_en <= ~cclk;
    for (int i = 1; i <= 600; i++) begin
      @(posedge clk);
      if (timer_tc === 1'h1) begin
        k++;
        if (k == 1) begin
          t = i;
        end
      end
    end
    chk(k == 1, "terminal count pulses");
    wb(RCT_ADDR_STAT, 1'h0, 8'h00);
    cap = q;
    osc_en <= 1'h0;
    wb(RCT_ADDR_CR0, 1'h1, 8'h00);
  endtask
  task automatic timer_runs();
    int ta, tb;
    logic [7:0] c;
    tmr(6'h03, 1'h0, ta, c);
    chk(c === 8'h00, "short capture");
    tmr(6'h07, 1'h0, tb, c);
    chk(tb - ta == 24, "timer length");
    tmr(6'h32, 1'h0, ta, c);
    chk(c === 8'h01, "long capture");
    wb(RCT_ADDR_STAT, 1'h0, 8'h00);
    chk(q === 8'h00, "capture not cleared");
    tmr(6'h03, 1'h1, ta, c);
    tmr(6'h07, 1'h1, tb, c);
    chk(tb - ta == 4, "count clock timer");
    wb(RCT_ADDR_CR2, 1'h1, 8'h00);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    rst = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    wdat = 32'h00000000;
    ev = 8'h00;
    osc_en = 1'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    regs();
    meas(2'h0, 1'h0, 300, 304, 313);
    meas(2'h1, 1'h1, 300, 299, 301);
    meas(2'h2, 1'h0, 300, 299, 301);
    meas(2'h2, 1'h1, 300, 299, 301);
    for (int d = 0; d < 4; d++) begin
      cont(d[1:0]);
    end
    route();
    timer_runs();
    finish_test();
  end
endmodule
